// File: design/logic_cell.sv
`timescale 1ns/1ns
// Function
// R1 - Register acts as D, T, JK or SR
// R2 - Data, clock, enable, clear; enabled edges only
// R3 - Clock and clear from global, pin or logic
// R4 - Enable from pin or logic only
// R5 - Combinational path bypasses the register
// R6 - Three outputs: local, row, column
// R7 - Each output picks lookup table or register
// R8 - Two outputs long-haul, one local
// R9 - Packing: table and register unrelated
// R10 - Packing disables cluster synchronous load
// R11 - Feedback register output into own table
// R12 - Registered and unregistered copies together
// R13 - Synchronous load captures alternate data; code loads sdata in D mode only, T, JK and SR use it as data
// R14 - Clear forces register to zero
module logic_cell
   import logic_cell_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [DATA_W-1:0] PWDATA_I,
   output logic [DATA_W-1:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input logic_cell_pkg::pin_in_t PIN_I,
   input logic_cell_pkg::fabric_in_t FABRIC_I,
   input wire logic [LUT_IN_W-1:0] LUT_DATA_I,
   output logic_cell_pkg::cell_out_t CELL_O,
   output logic REG_Q_O
);
   import logic_cell_pkg::*;

   cfg_t cfg_q;
   cfg_t cfg_d;
   logic [LUT_W-1:0] lut_q;
   logic [LUT_W-1:0] lut_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;
   logic [DATA_W-1:0] prdata_q;
   logic [DATA_W-1:0] prdata_d;

   logic [PIN_W-1:0] pin_meta_q;
   logic [PIN_W-1:0] pin_sync_q;
   pin_in_t pin_s;
   logic clk_src_prev_q;
   logic clk_src_prev_d;

   cell_out_t out_q;
   cell_out_t out_d;
   logic lut_reg_q;

   // Selects one of the three control sources
   function automatic logic pick_src(input src_t sel, input logic g, input logic p,
      input logic f);
      logic r;
      r = f;
      unique case (sel)
         SRC_GLOBAL: r = g;
         SRC_PIN: r = p;
         SRC_INT: r = f;
         default: r = f;
      endcase
      return r;
   endfunction : pick_src

   // Output source: register when the select bit is set
   function automatic logic pick_out(input logic sel, input logic lut_v, input logic reg_v);
      return sel ? reg_v : lut_v;
   endfunction : pick_out

   // APB decode
   wire access = PSEL_I & PENABLE_I;
   wire first_access = access & ~pready_q;
   wire done = access & pready_q;
   wire hit_cfg = PADDR_I == CFG_OFS;
   wire hit_lut = PADDR_I == LUT_OFS;
   wire hit_stat = PADDR_I == STAT_OFS;
   wire mapped = hit_cfg | hit_lut | hit_stat;
   wire wr_cfg = done & PWRITE_I & hit_cfg;
   wire wr_lut = done & PWRITE_I & hit_lut;

   // Pin sources cross in through two flops before anything looks at them
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end
      else
      begin
         pin_meta_q <= PIN_I;
         pin_sync_q <= pin_meta_q;
      end
   end

   assign pin_s = pin_sync_q;

   // Control source selection
   wire clk_src_lvl = pick_src(cfg_q.clk_src, pin_s.gclk, pin_s.clk, FABRIC_I.clk); // R3
   wire clr_lvl = pick_src(cfg_q.clr_src, pin_s.gclk, pin_s.clr, FABRIC_I.clr); // R3
   // No global network leg exists for the enable
   wire ena_lvl = (cfg_q.ena_src == ENA_INT) ? FABRIC_I.ena : pin_s.ena; // R4

   // The selected clock is a slow signal here; its rising edge becomes a step enable
   assign clk_src_prev_d = clk_src_lvl;
   wire clk_edge = clk_src_lvl & ~clk_src_prev_q;
   wire step = clk_edge & ena_lvl; // R2

   // Lookup table with optional register feedback
   logic reg_q;
   logic [LUT_IN_W-1:0] lut_idx;
   always_comb
   begin
      lut_idx = LUT_DATA_I;
      if (cfg_q.feedback)
      begin
         lut_idx[FB_IN] = reg_q; // R11
      end
   end
   wire lut_val = lut_q[lut_idx];

   // Packing feeds the register from its own fabric input and drops synchronous load
   wire sload_ok = FABRIC_I.sload & ~cfg_q.packing; // R10
   wire reg_src = cfg_q.packing ? FABRIC_I.pack_data : lut_val; // R9
   wire reg_d = sload_ok ? FABRIC_I.sdata : reg_src; // R13

   storage_element u_store (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .step_i(step),
      .clr_i(clr_lvl),
      .mode_i(cfg_q.mode),
      .d_i(reg_d),
      .k_i(FABRIC_I.k),
      .q_o(reg_q)
   ); // R1 R2 R14

   // A clear seen this cycle forces register-sourced outputs low at the next edge, the same edge that clears the register
   wire reg_view = clr_lvl ? 1'b0 : reg_q; // R14

   // Each output picks its own source, so one output may carry the table
   // while another carries the register
   always_comb
   begin
      out_d.local_out = pick_out(cfg_q.out_sel[OUT_LOCAL], lut_val, reg_view); // R6 R7 R8
      out_d.row_out = pick_out(cfg_q.out_sel[OUT_ROW], lut_val, reg_view); // R6 R7 R8 R12
      out_d.column_out = pick_out(cfg_q.out_sel[OUT_COLUMN], lut_val, reg_view); // R7 R9 R5
   end

   // Configuration writes
   always_comb
   begin
      cfg_d = cfg_q;
      lut_d = lut_q;
      if (wr_cfg)
      begin
         cfg_d = cfg_t'(PWDATA_I[CFG_W-1:0]);
      end
      if (wr_lut)
      begin
         lut_d = PWDATA_I[LUT_W-1:0];
      end
   end

   // Read data and handshake; one wait state per access
   logic [ST_W-1:0] status;
   always_comb
   begin
      status = '0;
      status[ST_Q] = reg_view;
      status[ST_LUT] = lut_val;
      status[ST_LOCAL] = out_q.local_out;
      status[ST_ROW] = out_q.row_out;
      status[ST_COLUMN] = out_q.column_out;
   end

   always_comb
   begin
      pready_d = first_access;
      pslverr_d = first_access & ~mapped;
      prdata_d = RD_ZERO;
      if (first_access & ~PWRITE_I)
      begin
         if (hit_cfg)
         begin
            prdata_d[CFG_W-1:0] = cfg_q;
         end
         else if (hit_lut)
         begin
            prdata_d[LUT_W-1:0] = lut_q;
         end
         else if (hit_stat)
         begin
            prdata_d[ST_W-1:0] = status;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         cfg_q <= CFG_RST;
         lut_q <= LUT_RST;
      end
      else
      begin
         cfg_q <= cfg_d;
         lut_q <= lut_d;
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= RD_ZERO;
      end
      else
      begin
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         clk_src_prev_q <= 1'b0;
         out_q <= '0;
         lut_reg_q <= 1'b0;
      end
      else
      begin
         clk_src_prev_q <= clk_src_prev_d;
         out_q <= out_d;
         lut_reg_q <= reg_view;
      end
   end

   assign PRDATA_O = prdata_q;
   assign PREADY_O = pready_q;
   assign PSLVERR_O = pslverr_q;
   assign CELL_O = out_q;
   assign REG_Q_O = lut_reg_q;

endmodule : logic_cell

// File: design/logic_cell_pkg.sv
package logic_cell_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int LUT_IN_W = 4;
   localparam int LUT_W = 16;
   localparam int OUT_N = 3;

   localparam logic [ADDR_W-1:0] CFG_OFS = 12'h000;
   localparam logic [ADDR_W-1:0] LUT_OFS = 12'h004;
   localparam logic [ADDR_W-1:0] STAT_OFS = 12'h008;

   localparam logic [LUT_W-1:0] LUT_RST = 16'h0000;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

   // Output select bit positions; a one picks the register
   localparam int OUT_LOCAL = 0;
   localparam int OUT_ROW = 1;
   localparam int OUT_COLUMN = 2;

   // Feedback replaces this lookup-table input with the register output
   localparam int FB_IN = 3;

   typedef enum logic [1:0] {
      FF_D = 2'b00,
      FF_T = 2'b01,
      FF_JK = 2'b10,
      FF_SR = 2'b11
   } ff_mode_t;

   typedef enum logic [1:0] {
      SRC_GLOBAL = 2'b00,
      SRC_PIN = 2'b01,
      SRC_INT = 2'b10
   } src_t;

   typedef enum logic {
      ENA_PIN = 1'b0,
      ENA_INT = 1'b1
   } ena_src_t;

   typedef struct packed {
      logic feedback;
      logic packing;
      logic [OUT_N-1:0] out_sel;
      ena_src_t ena_src;
      src_t clr_src;
      src_t clk_src;
      ff_mode_t mode;
   } cfg_t;

   localparam int CFG_W = $bits(cfg_t);
   localparam cfg_t CFG_RST = 12'h000;

   // Signals arriving from pins or the global network, asynchronous to CLK_I
   typedef struct packed {
      logic gclk;
      logic clk;
      logic clr;
      logic ena;
   } pin_in_t;

   localparam int PIN_W = $bits(pin_in_t);

   // Signals from neighbouring logic, already on CLK_I
   typedef struct packed {
      logic clk;
      logic clr;
      logic ena;
      logic sload;
      logic sdata;
      logic pack_data;
      logic k;
   } fabric_in_t;

   typedef struct packed {
      logic local_out;
      logic row_out;
      logic column_out;
   } cell_out_t;

   // Status word field positions
   localparam int ST_Q = 0;
   localparam int ST_LUT = 1;
   localparam int ST_LOCAL = 2;
   localparam int ST_ROW = 3;
   localparam int ST_COLUMN = 4;
   localparam int ST_W = 5;

endpackage : logic_cell_pkg

// File: design/storage_element.sv
`timescale 1ns/1ns
module storage_element
   import logic_cell_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic step_i,
   input wire logic clr_i,
   input ff_mode_t mode_i,
   input wire logic d_i,
   input wire logic k_i,
   output logic q_o
);

   function automatic logic next_q(input ff_mode_t mode, input logic q, input logic d,
      input logic k);
      logic r;
      r = q;
      unique case (mode)
         FF_D: r = d;
         FF_T: r = q ^ d;
         FF_JK: r = (d & ~q) | (~k & q);
         FF_SR: r = d ? ~k | q : q & ~k;
      endcase
      return r;
   endfunction : next_q

   logic q_q;
   logic q_d;

   // Clear beats every mode and the enable
   assign q_d = clr_i ? 1'b0 : (step_i ? next_q(mode_i, q_q, d_i, k_i) : q_q); // R14 R2 R1

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         q_q <= 1'b0;
      end
      else
      begin
         q_q <= q_d;
      end
   end

   assign q_o = q_q;

endmodule : storage_element

// File: tb/fabric_model.sv
`timescale 1ns/1ns
module fabric_model
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic go_i,
   output logic fclk_o
);
   // Neighbour clock idles low; one pulse per request
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
         fclk_o <= 1'b0;
      else
         fclk_o <= go_i & ~fclk_o;
endmodule : fabric_model

// File: tb/logic_cell_checker.sv
`timescale 1ns/1ns
module logic_cell_checker
   import logic_cell_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [DATA_W-1:0] PWDATA_I,
   input wire logic PREADY_O,
   input logic_cell_pkg::fabric_in_t FABRIC_I,
   input wire logic [LUT_IN_W-1:0] LUT_DATA_I,
   input logic_cell_pkg::cell_out_t CELL_O,
   input wire logic REG_Q_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   cfg_t cfg_q;
   logic [LUT_W-1:0] lut_q;
   logic [2:0] act_q;
   logic clk_q;
   wire wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
   wire lv = lut_q[LUT_DATA_I];
   wire fab = cfg_q.clk_src == SRC_INT && cfg_q.clr_src == SRC_INT && cfg_q.ena_src == ENA_INT;
   wire stp = fab & FABRIC_I.clk & ~clk_q & FABRIC_I.ena;
   wire dmd = stp & cfg_q.mode == FF_D & !cfg_q.feedback & !FABRIC_I.clr;
   // Shadow of the written setup, so checks follow what software chose
   always_ff @(posedge CLK_I or negedge RESET_N_I)
      if (!RESET_N_I)
      begin
         cfg_q <= CFG_RST;
         lut_q <= LUT_RST;
         act_q <= 3'h0;
         clk_q <= 1'b0;
      end
      else
      begin
         if (wr && PADDR_I == CFG_OFS)
            cfg_q <= cfg_t'(PWDATA_I[CFG_W-1:0]);
         if (wr && PADDR_I == LUT_OFS)
            lut_q <= PWDATA_I[LUT_W-1:0];
         act_q <= {act_q[1:0], stp | FABRIC_I.clr | wr};
         clk_q <= FABRIC_I.clk;
      end
   AST_LOCAL_LUT: assert property (!cfg_q.feedback && !cfg_q.out_sel[OUT_LOCAL] &&
      $stable(cfg_q) && $stable(lut_q) |=> CELL_O.local_out == $past(lv))
      else $error("local output not the table value");
   AST_ROW_LUT: assert property (!cfg_q.feedback && !cfg_q.out_sel[OUT_ROW] &&
      $stable(cfg_q) && $stable(lut_q) |=> CELL_O.row_out == $past(lv))
      else $error("row output not the table value");
   AST_ROW_REG: assert property (cfg_q.out_sel[OUT_ROW] && $stable(cfg_q) |=>
      CELL_O.row_out == REG_Q_O)
      else $error("row output not the register");
   AST_CLEAR: assert property (fab && FABRIC_I.clr |=> !REG_Q_O)
      else $error("clear did not force zero");
   AST_QUIET: assert property (fab && $changed(REG_Q_O) |-> act_q != 3'h0)
      else $error("register moved without enabled edge");
   AST_D_CAP: assert property ((dmd && !FABRIC_I.sload && !cfg_q.packing ##1
      !FABRIC_I.clr [*2]) |-> REG_Q_O == $past(lv, 2))
      else $error("D capture wrong");
   AST_SLOAD: assert property ((dmd && FABRIC_I.sload && !cfg_q.packing ##1
      !FABRIC_I.clr [*2]) |-> REG_Q_O == $past(FABRIC_I.sdata, 2))
      else $error("load data not captured");
   AST_PACK: assert property ((dmd && cfg_q.packing ##1 !FABRIC_I.clr [*2]) |->
      REG_Q_O == $past(FABRIC_I.pack_data, 2))
      else $error("packed register took wrong data");
endmodule : logic_cell_checker

// File: tb/logic_cell_tb_top.sv
`timescale 1ns/1ns
module logic_cell_tb_top;
   import logic_cell_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, go = 0, rdy, err, q, fclk;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0, prd;
   logic [3:0] pn = 4'h0, ld = 4'h0;
   logic [5:0] fab = 6'h00;
   cell_out_t co;
   int bad_count = 0, compares = 0;
   always #2 clk = ~clk;
   logic_cell dut (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
      .PSLVERR_O(err), .PIN_I(pn), .FABRIC_I({fclk, fab}), .LUT_DATA_I(ld),
      .CELL_O(co), .REG_Q_O(q));
   fabric_model fm (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .fclk_o(fclk));
   task complete_run;
      $display("mismatches %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
      int n;
      logic [31:0] rd;
      logic er;
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      // Ready is read mid-cycle, the value the next rising edge samples
      @(negedge clk);
      while (n < 20 && rdy !== 1'b1)
      begin
         n++;
         @(negedge clk);
      end
      if (n == 20)
      begin
         bad_count++;
         complete_run;
      end
      rd = prd;
      er = err;
      @(posedge clk);
      if (!w)
         chk(rd, d);
      chk({31'h0, er}, {31'h0, e});
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   // Latency is fixed by the clock pulse, register and output stages
   task step;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (5) @(posedge clk);
   endtask : step
   task regs;
      apb(1'b0, CFG_OFS, 32'h0, 1'b0);
      apb(1'b0, LUT_OFS, 32'h0, 1'b0);
      apb(1'b0, 12'h00C, 32'h0, 1'b1);
      apb(1'b1, CFG_OFS, 32'hFFFF_FFFF, 1'b0);
      apb(1'b0, CFG_OFS, 32'h0000_0FFF, 1'b0);
   endtask : regs
   task comb;
      apb(1'b1, LUT_OFS, 32'h0000_8000, 1'b0);
      apb(1'b1, CFG_OFS, 32'h0000_0068, 1'b0);
      ld <= 4'hF;
      repeat (3) @(posedge clk);
      chk(32'(co), 32'h7);
      ld <= 4'hE;
      repeat (3) @(posedge clk);
      chk(32'(co), 32'h0);
   endtask : comb
   task modes;
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, CFG_OFS, 32'h0000_0368 + 32'(m), 1'b0);
         ld <= 4'hF;
         fab <= 6'h31;
         repeat (3) @(posedge clk);
         chk(32'(q), 32'h0);
         fab <= 6'h11;
         step;
         chk(32'({q, co}), (m != 3) ? 32'hF : 32'h4);
         step;
         chk(32'({q, co}), (m == 0) ? 32'hF : 32'h4);
         fab <= 6'h01;
         step;
         chk(32'({q, co}), (m == 0) ? 32'hF : 32'h4);
      end
   endtask : modes
   task loads;
      apb(1'b1, CFG_OFS, 32'h0000_0368, 1'b0);
      ld <= 4'hE;
      fab <= 6'h1C;
      step;
      chk(32'(q), 32'h1);
      apb(1'b1, CFG_OFS, 32'h0000_0768, 1'b0);
      ld <= 4'hF;
      step;
      chk(32'({q, co}), 32'h4);
   endtask : loads
   task fback;
      apb(1'b1, LUT_OFS, 32'h0000_0080, 1'b0);
      apb(1'b1, CFG_OFS, 32'h0000_0B68, 1'b0);
      ld <= 4'h7;
      fab <= 6'h10;
      repeat (3) @(posedge clk);
      chk(32'({q, co}), 32'h4);
      step;
      chk(32'({q, co}), 32'hB);
      apb(1'b0, STAT_OFS, 32'h0000_0019, 1'b0);
   endtask : fback
   task pins;
      for (int s = 0; s < 2; s++)
      begin
         apb(1'b1, CFG_OFS, 32'h0000_0321 + 32'(s * 4), 1'b0);
         pn <= 4'hD;
         @(posedge clk);
         pn <= 4'h1;
         repeat (8) @(posedge clk);
         chk(32'(q), 32'(s));
      end
      apb(1'b1, CFG_OFS, 32'h0000_0315, 1'b0);
      pn <= 4'h3;
      @(posedge clk);
      pn <= 4'h1;
      repeat (8) @(posedge clk);
      chk(32'(q), 32'h0);
   endtask : pins
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      regs;
      comb;
      modes;
      loads;
      fback;
      pins;
      complete_run;
   end
endmodule : logic_cell_tb_top
bind logic_cell logic_cell_checker chk_i (.*);
